// ==== common/ots_pkg.sv ====
package ots_pkg;

  // -------------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] OTS_OFF_CTRL    = 8'h00;
  localparam logic [7:0] OTS_OFF_TIMING  = 8'h04;
  localparam logic [7:0] OTS_OFF_DELAY   = 8'h08;
  localparam logic [7:0] OTS_OFF_GASLOAD = 8'h0c;
  localparam logic [7:0] OTS_OFF_OILLOAD = 8'h10;
  localparam logic [7:0] OTS_OFF_TRIM    = 8'h14;
  localparam logic [7:0] OTS_OFF_O2MIN   = 8'h18;
  localparam logic [7:0] OTS_OFF_STATUS  = 8'h1c;
  localparam logic [7:0] OTS_OFF_AIR     = 8'h20;

  // -------------------------------------------------------------------------
  // Reset values and constants
  // -------------------------------------------------------------------------
  localparam logic [31:0] OTS_RST_TIMING  = 32'h0302_0064;
  localparam logic [31:0] OTS_RST_DELAY   = 32'h0000_0064;
  localparam logic [31:0] OTS_RST_LOAD    = 32'h0000_1410;
  localparam logic [31:0] OTS_RST_TRIM    = 32'h0010_0000;
  localparam logic [31:0] OTS_RST_O2MIN   = 32'h0000_0000;
  localparam logic [7:0]  OTS_HYST_PCT    = 8'h05;
  localparam logic [7:0]  OTS_CHECK_TAUS  = 8'h03;
  localparam logic [7:0]  OTS_LAMBDA_ONE  = 8'h10;
  localparam logic [17:0] OTS_MV_ONE      = 18'h00400;
  localparam logic [3:0]  OTS_ERR_NONE    = 4'h0;
  localparam logic [3:0]  OTS_ERR_MINLIM  = 4'h1;
  localparam logic [3:0]  OTS_ERR_MAXAL   = 4'h2;
  localparam logic [3:0]  OTS_ERR_MEAS    = 4'h3;
  localparam logic [3:0]  OTS_ERR_TEST    = 4'h4;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OTS_MAN_OFF,
    OTS_ALARM_ONLY,
    OTS_TRIM_ALARM,
    OTS_EARLY_START,
    OTS_SELF_DISABLED
  } ots_mode_t;

  typedef enum logic [1:0] {
    OTS_LEARNED_FACTOR,
    OTS_THEORETICAL,
    OTS_UNITY_FACTOR
  } ots_method_t;

  typedef struct packed {
    logic meas_valid;
    logic meas_error;
    logic module_error;
    logic sensor_error;
    logic test_error;
    logic max_alarm;
    logic min_alarm;
    logic at_temp;
    logic test_ok;
  } ots_sensor_t;

endpackage

// ==== logic/ots_supervisor.sv ====
// Contract
// - +10% manipulated value offsets -10% air density.
// - Three selectable precontrol methods.
// - Learned method applies learned lambda factor.
// - Theoretical method ignores lambda for density.
// - Unity method uses lambda one always.
// - Manual off disables trim and alarm.
// - Alarm-only enables alarm, trim stays off.
// - Alarm modes withhold startup until sensor hot.
// - Alarm modes: faults shut down, counter locks out.
// - Early start: start now, trim after test.
// - Early start faults force self-disabled mode; code ignores a fault rising while minimum alarm is active.
// - Early start minimum alarm suspends trim.
// - After three taus, recheck oxygen, re-release.
// - Still low: shutdown, repeat, limit self-disables.
// - Self-disabled: curves, indicate, hold error code.
// - Self-disabled ignores errors and maximum alarm.
// - Self-disabled minimum alarm: shutdown after delay.
// - Trim off below low-fire adaption point.
// - Below either threshold, trim and alarm off.
// - Five percent above: reinitialise, re-enable both.
// - Lock period starts at phase 60 entry.
`timescale 1ns/1ps
module ots_supervisor #(
  parameter int TAU_W = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           load_pct,
  input  wire logic                 fuel_oil,
  input  wire logic                 phase60_entry,
  input  wire logic [11:0]          o2_value,
  input  wire ots_pkg::ots_sensor_t sensor,
  input  wire logic [15:0]          air_base,
  input  wire logic [15:0]          air_reduction,
  output logic                      trim_enable,
  output logic                      alarm_enable,
  output logic                      startup_permit,
  output logic                      follow_curves,
  output logic                      self_disabled_ind,
  output logic                      shutdown_req,
  output logic                      repeat_req,
  output logic                      lockout,
  output logic                      trim_reinit,
  output logic      [15:0]          air_rate
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOCK,
    ST_RUN,
    ST_SUSPEND,
    ST_SD_WAIT,
    ST_SD_DELAY
  } ots_state_t;

  // -------------------------------------------------------------------------
  // APB register file
  // -------------------------------------------------------------------------
  ots_pkg::ots_mode_t   mode;
  ots_pkg::ots_method_t method;
  logic [31:0]          reg_timing;
  logic [31:0]          reg_delay;
  logic [31:0]          reg_gas;
  logic [31:0]          reg_oil;
  logic [31:0]          reg_trim;
  logic [31:0]          reg_o2min;
  logic [3:0]           viol_cnt;
  logic [3:0]           err_code;
  logic                 low_load;
  ots_state_t           state;
  logic                 acc;
  logic                 wr;
  logic                 mode_wr;
  logic [31:0]          ctrl_new;
  logic                 force_sd;
  logic [3:0]           force_code;

  assign acc      = psel && penable && pready;
  assign wr       = acc && pwrite;
  assign ctrl_new = merge_strb({26'h0, method, 1'b0, mode}, pwdata, pstrb);
  assign mode_wr  = wr && (paddr == ots_pkg::OTS_OFF_CTRL) && pstrb[0] && (pwdata[2:0] <= 3'h4);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable)
      begin
        unique case (paddr)
          ots_pkg::OTS_OFF_CTRL:    prdata <= {26'h0, method, 1'b0, mode};
          ots_pkg::OTS_OFF_TIMING:  prdata <= reg_timing;
          ots_pkg::OTS_OFF_DELAY:   prdata <= reg_delay;
          ots_pkg::OTS_OFF_GASLOAD: prdata <= reg_gas;
          ots_pkg::OTS_OFF_OILLOAD: prdata <= reg_oil;
          ots_pkg::OTS_OFF_TRIM:    prdata <= reg_trim;
          ots_pkg::OTS_OFF_O2MIN:   prdata <= reg_o2min;
          ots_pkg::OTS_OFF_STATUS:  prdata <= {13'h0, state, err_code, viol_cnt, lockout, low_load,
                                               startup_permit, alarm_enable, trim_enable, mode};
          ots_pkg::OTS_OFF_AIR:     prdata <= {16'h0, air_rate};
          default:                  pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      method     <= ots_pkg::OTS_LEARNED_FACTOR;
      reg_timing <= ots_pkg::OTS_RST_TIMING;
      reg_delay  <= ots_pkg::OTS_RST_DELAY;
      reg_gas    <= ots_pkg::OTS_RST_LOAD;
      reg_oil    <= ots_pkg::OTS_RST_LOAD;
      reg_trim   <= ots_pkg::OTS_RST_TRIM;
      reg_o2min  <= ots_pkg::OTS_RST_O2MIN;
    end
    else if (wr)
    begin
      unique case (paddr)
        ots_pkg::OTS_OFF_CTRL:
        begin
          if (pstrb[0] && ctrl_new[5:4] != 2'h3)
          begin
            method <= ots_pkg::ots_method_t'(ctrl_new[5:4]);
          end
        end
        ots_pkg::OTS_OFF_TIMING:  reg_timing <= merge_strb(reg_timing, pwdata, pstrb) & 32'h0fff_ffff;
        ots_pkg::OTS_OFF_DELAY:   reg_delay  <= merge_strb(reg_delay, pwdata, pstrb) & 32'h00ff_ffff;
        ots_pkg::OTS_OFF_GASLOAD: reg_gas    <= merge_strb(reg_gas, pwdata, pstrb) & 32'h0000_ffff;
        ots_pkg::OTS_OFF_OILLOAD: reg_oil    <= merge_strb(reg_oil, pwdata, pstrb) & 32'h0000_ffff;
        ots_pkg::OTS_OFF_TRIM:    reg_trim   <= merge_strb(reg_trim, pwdata, pstrb) & 32'h00ff_ffff;
        ots_pkg::OTS_OFF_O2MIN:   reg_o2min  <= merge_strb(reg_o2min, pwdata, pstrb) & 32'h0000_0fff;
        default:
        begin
        end
      endcase
    end
  end

  // Hardware self-disable wins over a software mode write in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode     <= ots_pkg::OTS_MAN_OFF;
      err_code <= ots_pkg::OTS_ERR_NONE;
    end
    else if (force_sd)
    begin
      mode     <= ots_pkg::OTS_SELF_DISABLED;
      err_code <= force_code;
    end
    else if (mode_wr)
    begin
      mode     <= ots_pkg::ots_mode_t'(pwdata[2:0]);
      err_code <= ots_pkg::OTS_ERR_NONE;
    end
  end

  // -------------------------------------------------------------------------
  // Load limitation
  // -------------------------------------------------------------------------
  logic [7:0] thr;
  logic [8:0] thr_hi;

  assign thr    = fuel_oil ? max8(reg_oil[7:0], reg_oil[15:8]) : max8(reg_gas[7:0], reg_gas[15:8]);
  assign thr_hi = {1'b0, thr} + {1'b0, ots_pkg::OTS_HYST_PCT};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_load <= 1'b1;
    end
    else if (load_pct < thr)
    begin
      low_load <= 1'b1;
    end
    else if ({1'b0, load_pct} >= thr_hi)
    begin
      low_load <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Tau timer and alarm delay
  // -------------------------------------------------------------------------
  logic [TAU_W-1:0] tick;
  logic [7:0]       taus_left;
  logic             tmr_busy;
  logic             tmr_start;
  logic [7:0]       tmr_taus;
  logic             tmr_done;
  logic [23:0]      dly;
  logic             dly_start;

  assign tmr_done = tmr_busy && (tick <= TAU_W'(1)) && (taus_left <= 8'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick      <= '0;
      taus_left <= 8'h00;
      tmr_busy  <= 1'b0;
    end
    else if (tmr_start)
    begin
      tick      <= reg_timing[TAU_W-1:0];
      taus_left <= tmr_taus;
      tmr_busy  <= 1'b1;
    end
    else if (tmr_busy)
    begin
      if (tick > TAU_W'(1))
      begin
        tick <= tick - TAU_W'(1);
      end
      else if (taus_left > 8'h01)
      begin
        taus_left <= taus_left - 8'h01;
        tick      <= reg_timing[TAU_W-1:0];
      end
      else
      begin
        tmr_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dly <= 24'h0;
    end
    else if (dly_start)
    begin
      dly <= reg_delay[23:0];
    end
    else if (dly != 24'h0)
    begin
      dly <= dly - 24'h1;
    end
  end

  // -------------------------------------------------------------------------
  // Supervisor state machine
  // -------------------------------------------------------------------------
  logic       min_prev;
  logic       min_rise;
  logic       fault;
  logic       fault_prev;
  logic       fault_rise;
  logic       ev_shut;
  logic       ev_count;
  logic       ev_lock;
  logic       ev_reinit;
  logic       trim_mode;
  logic       alarm_mode;
  logic [3:0] viol_next;
  ots_state_t next_state;

  assign min_rise   = sensor.min_alarm && !min_prev;
  assign trim_mode  = (mode == ots_pkg::OTS_TRIM_ALARM) || (mode == ots_pkg::OTS_EARLY_START);
  assign alarm_mode = (mode == ots_pkg::OTS_ALARM_ONLY) || (mode == ots_pkg::OTS_TRIM_ALARM);
  assign fault      = sensor.meas_error || sensor.module_error || sensor.sensor_error || sensor.max_alarm ||
                      (mode == ots_pkg::OTS_EARLY_START && sensor.test_error) ||
                      (alarm_mode && sensor.min_alarm);
  assign fault_rise = fault && !fault_prev;
  assign viol_next  = viol_cnt + 4'h1;

  always_comb
  begin
    next_state = state;
    tmr_start  = 1'b0;
    tmr_taus   = ots_pkg::OTS_CHECK_TAUS;
    dly_start  = 1'b0;
    ev_shut    = 1'b0;
    ev_count   = 1'b0;
    ev_lock    = 1'b0;
    ev_reinit  = 1'b0;
    force_sd   = 1'b0;
    force_code = ots_pkg::OTS_ERR_NONE;
    if (alarm_mode && fault_rise && !low_load)
    begin
      ev_shut    = 1'b1;
      ev_count   = 1'b1;
      ev_lock    = viol_next >= reg_timing[27:24];
      next_state = ST_IDLE;
    end
    else if (mode == ots_pkg::OTS_EARLY_START && fault_rise && !sensor.min_alarm)
    begin
      force_sd   = 1'b1;
      force_code = sensor.max_alarm ? ots_pkg::OTS_ERR_MAXAL :
                   sensor.test_error ? ots_pkg::OTS_ERR_TEST : ots_pkg::OTS_ERR_MEAS;
      next_state = ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (mode == ots_pkg::OTS_SELF_DISABLED && min_rise && sensor.meas_valid)
          begin
            tmr_start  = 1'b1;
            next_state = ST_SD_WAIT;
          end
          else if (trim_mode && phase60_entry)
          begin
            tmr_start  = 1'b1;
            tmr_taus   = reg_timing[23:16];
            next_state = ST_LOCK;
          end
        end
        ST_LOCK:
        begin
          if (tmr_done)
          begin
            ev_reinit  = 1'b1;
            next_state = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (mode == ots_pkg::OTS_EARLY_START && min_rise)
          begin
            tmr_start  = 1'b1;
            next_state = ST_SUSPEND;
          end
        end
        ST_SUSPEND:
        begin
          if (min_rise)
          begin
            tmr_start = 1'b1;
          end
          else if (tmr_done)
          begin
            if (o2_value > reg_o2min[11:0])
            begin
              next_state = ST_RUN;
            end
            else
            begin
              ev_shut    = 1'b1;
              ev_count   = 1'b1;
              force_sd   = viol_next >= reg_timing[27:24];
              force_code = ots_pkg::OTS_ERR_MINLIM;
              next_state = ST_IDLE;
            end
          end
        end
        ST_SD_WAIT:
        begin
          if (!sensor.min_alarm || !sensor.meas_valid)
          begin
            next_state = ST_IDLE;
          end
          else if (tmr_done)
          begin
            dly_start  = 1'b1;
            next_state = ST_SD_DELAY;
          end
        end
        ST_SD_DELAY:
        begin
          if (!sensor.min_alarm || !sensor.meas_valid)
          begin
            next_state = ST_IDLE;
          end
          else if (dly == 24'h0 && !dly_start)
          begin
            ev_shut    = 1'b1;
            next_state = ST_IDLE;
          end
        end
      endcase
    end
    if (low_load && (state == ST_RUN || state == ST_SUSPEND))
    begin
      next_state = ST_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= ST_IDLE;
      min_prev   <= 1'b0;
      fault_prev <= 1'b0;
      viol_cnt   <= 4'h0;
      lockout    <= 1'b0;
    end
    else
    begin
      min_prev   <= sensor.min_alarm;
      fault_prev <= fault;
      if (ev_count)
      begin
        viol_cnt <= viol_next;
      end
      else if (mode_wr)
      begin
        viol_cnt <= 4'h0;
      end
      if (ev_lock)
      begin
        lockout <= 1'b1;
      end
      else if (mode_wr)
      begin
        lockout <= 1'b0;
      end
      state <= (mode_wr && !force_sd) ? ST_IDLE : next_state;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs and precontrol
  // -------------------------------------------------------------------------
  logic               next_trim;
  logic signed [24:0] mv_prod;
  logic signed [15:0] mv_eff;
  logic signed [17:0] factor;
  logic signed [34:0] dens;
  logic [7:0]         lam_red;
  logic [23:0]        red_p;
  logic signed [25:0] diff;

  assign next_trim = trim_mode && state == ST_RUN && !low_load &&
                     (mode != ots_pkg::OTS_EARLY_START || (sensor.at_temp && sensor.test_ok));
  assign mv_prod   = $signed(reg_trim[15:0]) * $signed({1'b0, reg_trim[23:16]});
  assign mv_eff    = (method == ots_pkg::OTS_LEARNED_FACTOR) ? mv_prod[19:4] : $signed(reg_trim[15:0]);
  assign factor    = $signed(ots_pkg::OTS_MV_ONE) + 18'(mv_eff);
  assign dens      = $signed({1'b0, air_base}) * factor;
  assign lam_red   = (method == ots_pkg::OTS_UNITY_FACTOR) ? ots_pkg::OTS_LAMBDA_ONE : reg_trim[23:16];
  assign red_p     = air_reduction * lam_red;
  assign diff      = 26'($signed(dens[34:10])) - $signed({6'h0, red_p[23:4]});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_enable       <= 1'b0;
      alarm_enable      <= 1'b0;
      startup_permit    <= 1'b0;
      follow_curves     <= 1'b1;
      self_disabled_ind <= 1'b0;
      shutdown_req      <= 1'b0;
      repeat_req        <= 1'b0;
      trim_reinit       <= 1'b0;
      air_rate          <= 16'h0;
    end
    else
    begin
      trim_enable       <= next_trim;
      follow_curves     <= !next_trim;
      alarm_enable      <= (alarm_mode || trim_mode || mode == ots_pkg::OTS_SELF_DISABLED) && !low_load;
      startup_permit    <= !alarm_mode || sensor.at_temp;
      self_disabled_ind <= mode == ots_pkg::OTS_SELF_DISABLED;
      shutdown_req      <= ev_shut;
      repeat_req        <= ev_count && !ev_lock && !force_sd;
      trim_reinit       <= ev_reinit || (trim_mode && low_load && load_pct >= thr &&
                                         {1'b0, load_pct} >= thr_hi);
      if (diff < 0)
      begin
        air_rate <= 16'h0;
      end
      else if (diff > 26'sh00ffff)
      begin
        air_rate <= 16'hffff;
      end
      else
      begin
        air_rate <= diff[15:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  a_man_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ots_pkg::OTS_MAN_OFF |=> !trim_enable && !alarm_enable && follow_curves)
    else $error("manual off left trim or alarm on");
  a_alarm_only_trim: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ots_pkg::OTS_ALARM_ONLY && !low_load |=> alarm_enable && !trim_enable)
    else $error("alarm only mode outputs wrong");
  a_startup_hold: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_mode && !sensor.at_temp |=> !startup_permit)
    else $error("startup permitted with cold sensor");
  a_early_force_sd: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ots_pkg::OTS_EARLY_START && fault_rise && !sensor.min_alarm |=> mode == ots_pkg::OTS_SELF_DISABLED)
    else $error("early start fault did not self disable");
  a_suspend_curves: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RUN && mode == ots_pkg::OTS_EARLY_START && min_rise && !fault_rise |=> ##1 follow_curves)
    else $error("minimum alarm did not suspend trim");
  a_low_load_off: assert property (@(posedge pclk) disable iff (!presetn)
    load_pct < thr |=> ##1 !trim_enable && !alarm_enable)
    else $error("trim or alarm active at low load");
  a_shut_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown_req |=> !shutdown_req)
    else $error("shutdown request longer than one cycle");
  a_sd_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ots_pkg::OTS_SELF_DISABLED && !mode_wr |=> mode == ots_pkg::OTS_SELF_DISABLED && !repeat_req)
    else $error("self disabled mode reacted to an error");
  a_lock_release: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_LOCK && tmr_done && !fault_rise && !mode_wr && !low_load |=> trim_reinit)
    else $error("lock period end did not reinitialise");

  c_early_suspend: cover property (@(posedge pclk) disable iff (!presetn) state == ST_SUSPEND ##1 state == ST_RUN);
  c_force_sd:      cover property (@(posedge pclk) disable iff (!presetn) force_sd);
  c_lockout:       cover property (@(posedge pclk) disable iff (!presetn) $rose(lockout));
  c_sd_shutdown:   cover property (@(posedge pclk) disable iff (!presetn) state == ST_SD_DELAY ##1 shutdown_req);

endmodule

// ==== tb/ots_sensor_model.sv ====
`timescale 1ns/1ps
module ots_sensor_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            hot,
  input  wire logic            fault_on,
  input  wire logic            min_on,
  output ots_pkg::ots_sensor_t sensor,
  output logic      [11:0]     o2_value
);
  logic [3:0] heat;

  // The probe reports valid, tested readings only after heating a while.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      heat <= 4'h0;
    else if (!hot)
      heat <= 4'h0;
    else if (heat != 4'hf)
      heat <= heat + 4'h1;

  assign sensor = '{meas_valid: heat > 4'h5, meas_error: fault_on, module_error: 1'b0,
                    sensor_error: 1'b0, test_error: 1'b0, max_alarm: 1'b0,
                    min_alarm: min_on, at_temp: heat > 4'h5, test_ok: heat > 4'h6};
  assign o2_value = 12'h200;
endmodule

// ==== tb/o2_trim_mode_supervisor_tb_top.sv ====
`timescale 1ns/1ps
module o2_trim_mode_supervisor_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  load_pct = 8'h32;
  logic        phase60 = 1'b0;
  logic        hot = 1'b0;
  logic        fault_on = 1'b0;
  logic        min_on = 1'b0;
  logic        fuel_oil = 1'b0;
  logic [15:0] air_base = 16'h1000;
  logic [15:0] air_red = 16'h0100;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, trim_enable, alarm_enable, startup_permit, follow_curves;
  logic        self_disabled_ind, shutdown_req, repeat_req, lockout, trim_reinit;
  logic [11:0] o2_value;
  logic [15:0] air_rate;
  ots_pkg::ots_sensor_t sensor;
  int          fail_count = 0;
  int          n_tests = 0;
  int          n_shut = 0;
  int          n_reinit = 0;
  int          base;

  always #5 pclk = ~pclk;
  // Pulses are tallied so that checks need not hit their exact cycle.
  always @(posedge pclk)
  begin
    n_shut <= n_shut + int'(shutdown_req);
    n_reinit <= n_reinit + int'(trim_reinit);
  end

  ots_supervisor ots_supervisor_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .load_pct, .fuel_oil, .phase60_entry(phase60), .o2_value, .sensor,
    .air_base, .air_reduction(air_red), .trim_enable, .alarm_enable, .startup_permit,
    .follow_curves, .self_disabled_ind, .shutdown_req, .repeat_req, .lockout, .trim_reinit, .air_rate
  );
  ots_sensor_model ots_sensor_model_i (.pclk, .presetn, .hot, .fault_on, .min_on, .sensor, .o2_value);

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic p60;
    phase60 <= 1'b1;
    wt(1);
    phase60 <= 1'b0;
  endtask

  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #60000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    wt(12);
    presetn <= 1'b1;
    apb(1'b0, ots_pkg::OTS_OFF_TIMING, 32'h0);
    chk("timing", ots_pkg::OTS_RST_TIMING, rd);
    apb(1'b0, ots_pkg::OTS_OFF_GASLOAD, 32'h0);
    chk("gasload", ots_pkg::OTS_RST_LOAD, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("off", 32'h3, {trim_enable, alarm_enable, follow_curves, startup_permit});
    apb(1'b1, ots_pkg::OTS_OFF_CTRL, 32'h1);
    wt(3);
    chk("cold", 32'h4, {alarm_enable, trim_enable, startup_permit});
    hot <= 1'b1;
    wt(12);
    chk("hot", 32'h1, startup_permit);
    apb(1'b1, ots_pkg::OTS_OFF_TIMING, 32'h0102_0064);
    fault_on <= 1'b1;
    wt(2);
    fault_on <= 1'b0;
    wt(3);
    chk("shut", 32'h3, {n_shut == 1, lockout});
    apb(1'b1, ots_pkg::OTS_OFF_CTRL, 32'h2);
    base = n_reinit;
    p60();
    wt(150);
    chk("locked", 32'h0, {trim_enable, lockout});
    wt(60);
    chk("run", 32'h3, {n_reinit - base == 1, trim_enable});
    load_pct <= 8'd10;
    wt(3);
    chk("low", 32'h1, {trim_enable, alarm_enable, follow_curves});
    load_pct <= 8'd24;
    wt(3);
    chk("hyst", 32'h0, trim_enable);
    load_pct <= 8'd25;
    wt(3);
    chk("back", 32'h3, {n_reinit - base == 2, trim_enable});
    apb(1'b1, ots_pkg::OTS_OFF_CTRL, 32'h3);
    p60();
    wt(215);
    chk("early", 32'h1, trim_enable);
    min_on <= 1'b1;
    wt(3);
    chk("minsusp", 32'h1, {trim_enable, follow_curves});
    wt(310);
    chk("recheck", 32'h1, trim_enable);
    min_on <= 1'b0;
    fault_on <= 1'b1;
    wt(3);
    fault_on <= 1'b0;
    chk("selfdis", 32'h3, {self_disabled_ind, follow_curves});
    apb(1'b0, ots_pkg::OTS_OFF_STATUS, 32'h0);
    chk("status", 32'h1c, {rd[15:12], rd[2:0]});
    apb(1'b1, ots_pkg::OTS_OFF_TRIM, 32'h0020_0066);
    apb(1'b0, ots_pkg::OTS_OFF_AIR, 32'h0);
    chk("air_learned", 32'h1130, rd);
    apb(1'b1, ots_pkg::OTS_OFF_CTRL, 32'h14);
    apb(1'b0, ots_pkg::OTS_OFF_AIR, 32'h0);
    chk("air_theory", 32'h0f98, rd);
    apb(1'b1, ots_pkg::OTS_OFF_CTRL, 32'h34);
    apb(1'b0, ots_pkg::OTS_OFF_AIR, 32'h0);
    chk("air_keep", 32'h0f98, rd);
    apb(1'b1, ots_pkg::OTS_OFF_CTRL, 32'h24);
    apb(1'b0, ots_pkg::OTS_OFF_AIR, 32'h0);
    chk("air_unity", 32'h1098, rd);
    chk("sd_alarm", 32'h1, alarm_enable);
    base = n_shut;
    min_on <= 1'b1;
    wt(390);
    chk("sd_early", 32'h0, n_shut - base);
    wt(20);
    chk("sd_shut", 32'h1, n_shut - base);
    apb(1'b1, ots_pkg::OTS_OFF_OILLOAD, 32'h3c00);
    fuel_oil <= 1'b1;
    wt(3);
    chk("oil", 32'h0, alarm_enable);
    finish_test();
  end
endmodule
